/* File: hw/wsc_pkg.sv */
package wsc_pkg;
   localparam int unsigned CLK_HZ        = 40_000_000;
   localparam int unsigned DEB_TIME_US   = 5000;
   localparam int unsigned FLASH_TIME_MS = 250;
   localparam int unsigned DEB_CYC   = CLK_HZ / 1_000_000 * DEB_TIME_US;
   localparam int unsigned FLASH_CYC = CLK_HZ / 1000 * FLASH_TIME_MS;

   localparam logic [7:0] A_CTRL  = 8'h00;
   localparam logic [7:0] A_LOAD  = 8'h04;
   localparam logic [7:0] A_NEXT  = 8'h08;
   localparam logic [7:0] A_STAT  = 8'h0c;
   localparam logic [7:0] A_MASK  = 8'h10;
   localparam logic [7:0] A_COUNT = 8'h14;

   // field positions inside the register words
   localparam int F_FUNC   = 0;
   localparam int F_PO     = 8;
   localparam int F_SHOW   = 10;
   localparam int F_BASE   = 16;
   localparam int F_LCNT   = 0;
   localparam int F_FIRST  = 16;
   localparam int F_LAST   = 24;
   localparam int F_NWELD  = 0;
   localparam int F_NOFF   = 8;
   localparam int F_NEMPTY = 16;
   localparam int F_CNT    = 0;
   localparam int F_STEP   = 16;
   localparam int F_ENDRO  = 24;

   localparam logic [7:0] EXT_EN_CODE   = 8'h05;
   localparam logic [7:0] NEXT_OFF_RST  = 8'h99;
   localparam logic [7:0] NEXT_WELD_END = 8'h01;
   localparam logic [3:0] BCD_NINE      = 4'h9;
   localparam logic [3:0] BCD_MAX_GROUP = 4'h4;
   localparam logic [1:0] PO_NONE       = 2'h0;
   localparam logic [1:0] PO_IO         = 2'h1;
   localparam logic [1:0] PO_IT         = 2'h2;

   localparam int NIRQ     = 4;
   localparam int IRQ_END  = 0;
   localparam int IRQ_EXT  = 1;
   localparam int IRQ_AUTO = 2;
   localparam int IRQ_MAN  = 3;

   localparam int NPIN     = 6;
   localparam int P_ENTER  = 0;
   localparam int P_DATA1  = 1;
   localparam int P_DATA10 = 2;
   localparam int P_OTHER  = 3;
   localparam int P_ESTOP  = 4;
   localparam int P_EXT    = 5;

   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_END = 2'b10
   } wsc_st_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } wsc_req_t;

   typedef struct packed {
      logic enter;
      logic data1;
      logic data10;
      logic other;
   } wsc_keys_t;
endpackage

/* File: hw/wsc_top.sv */
`timescale 1ns/1ps
module wsc_top #(
   parameter int unsigned DEB_CYC   = wsc_pkg::DEB_CYC,
   parameter int unsigned FLASH_CYC = wsc_pkg::FLASH_CYC
) (
   input  wire logic              clk,                 // 40 mhz clock
   input  wire logic              reset,               // sync, active high
   input  wire wsc_pkg::wsc_req_t req,                 // register request
   output logic [31:0]            rdata,               // read data
   output logic                   irq,                 // level interrupt
   input  wire wsc_pkg::wsc_keys_t keys,               // panel keys, async
   input  wire logic              estop,               // emergency stop
   input  wire logic              external_reset_input, // high = open
   input  wire logic              weld_done,           // one weld completed
   input  wire logic              seq_start,           // sequence begins
   input  wire logic              seq_end,             // sequence finished
   output logic                   end_msg,             // end message shown
   output logic                   disp_flash,          // blink phase
   output logic                   valve_io,            // process valve
   output logic                   valve_it,            // third valve
   output logic                   show_count,          // show remaining
   output logic [15:0]            disp_count,          // bcd count
   output logic [7:0]             disp_step            // bcd step
);
   localparam int DW = $clog2(DEB_CYC + 1);
   localparam int FW = $clog2(FLASH_CYC + 1);
   localparam logic [DW-1:0] DEB_LAST   = DW'(DEB_CYC - 1);
   localparam logic [FW-1:0] FLASH_LAST = FW'(FLASH_CYC - 1);

   typedef struct packed {
      logic [wsc_pkg::NPIN-1:0] sync1;
      logic [wsc_pkg::NPIN-1:0] sync2;
      logic [wsc_pkg::NPIN-1:0] prev;
      logic [DW-1:0]            deb_cnt;
      logic                     deb_lvl;
      logic [7:0]               ext_func;
      logic [1:0]               po_sel;
      logic                     show_sel;
      logic [7:0]               base;
      logic [15:0]              load_cnt;
      logic [7:0]               first;
      logic [7:0]               last;
      logic [7:0]               nxt_weld;
      logic [7:0]               nxt_off;
      logic                     nxt_empty;
      logic [15:0]              count;
      logic [7:0]               step;
      wsc_pkg::wsc_st_t         st;
      logic                     end_msg;
      logic [FW-1:0]            flash_cnt;
      logic                     flash_on;
      logic                     show_cnt;
      logic [wsc_pkg::NIRQ-1:0] stat;
      logic [wsc_pkg::NIRQ-1:0] mask;
      logic                     irq;
      logic                     valve_io;
      logic                     valve_it;
      logic [31:0]              rdata;
   } wsc_state_t;

   wsc_state_t s_q;
   wsc_state_t s_d;

   function automatic logic [15:0] bcd_dec(input logic [15:0] v);
      logic [15:0] r;
      logic        b;
      r = v;
      b = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (b) begin
            if (v[4*i +: 4] == 4'h0) begin
               r[4*i +: 4] = wsc_pkg::BCD_NINE;
            end else begin
               r[4*i +: 4] = v[4*i +: 4] - 4'h1;
               b = 1'b0;
            end
         end
      end
      return r;
   endfunction

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      logic [7:0] r;
      logic       c;
      r = v;
      c = 1'b1;
      for (int i = 0; i < 2; i++) begin
         if (c) begin
            if (v[4*i +: 4] >= wsc_pkg::BCD_NINE) begin
               r[4*i +: 4] = 4'h0;
            end else begin
               r[4*i +: 4] = v[4*i +: 4] + 4'h1;
               c = 1'b0;
            end
         end
      end
      return r;
   endfunction

   logic [wsc_pkg::NPIN-1:0] pins;
   logic [wsc_pkg::NIRQ-1:0] ev;
   logic [wsc_pkg::NIRQ-1:0] clr;
   logic [3:0]               press;
   logic                     ext_req;
   logic                     combo_now;
   logic                     combo_was;
   logic                     man_rst;
   logic                     ext_rst;
   logic                     count_ok;
   logic                     stop_evt;
   logic [15:0]              nxt_cnt;

   assign pins = {external_reset_input, estop, keys.other, keys.data10,
                  keys.data1, keys.enter};

   always_comb begin
      s_d = s_q;
      ev = '0;
      clr = '0;
      ext_req = 1'b0;
      nxt_cnt = bcd_dec(s_q.count);

      // pin synchronisers, first stage read only by the second
      s_d.sync1 = pins;
      s_d.sync2 = s_q.sync1;
      s_d.prev = s_q.sync2;

      // closed switch holds input low; a stable open is one request
      if (s_q.sync2[wsc_pkg::P_EXT] != s_q.deb_lvl) begin
         s_d.deb_cnt = s_q.deb_cnt + DW'(1);
         if (s_q.deb_cnt >= DEB_LAST) begin
            s_d.deb_lvl = s_q.sync2[wsc_pkg::P_EXT];
            s_d.deb_cnt = '0;
            ext_req = s_q.sync2[wsc_pkg::P_EXT];
         end
      end else begin
         s_d.deb_cnt = '0;
      end
      ext_rst = ext_req && (s_q.ext_func == wsc_pkg::EXT_EN_CODE);

      press = s_q.sync2[wsc_pkg::P_OTHER:wsc_pkg::P_ENTER]
              & ~s_q.prev[wsc_pkg::P_OTHER:wsc_pkg::P_ENTER];
      combo_now = s_q.sync2[wsc_pkg::P_ENTER] && s_q.sync2[wsc_pkg::P_DATA1]
                  && s_q.sync2[wsc_pkg::P_DATA10];
      combo_was = s_q.prev[wsc_pkg::P_ENTER] && s_q.prev[wsc_pkg::P_DATA1]
                  && s_q.prev[wsc_pkg::P_DATA10];
      man_rst = combo_now && !combo_was;
      stop_evt = (|press) || (s_q.sync2[wsc_pkg::P_ESTOP]
                 && !s_q.prev[wsc_pkg::P_ESTOP]);
      count_ok = (s_q.base[3:0] == 4'h0)
                 && (s_q.base[7:4] <= wsc_pkg::BCD_MAX_GROUP);

      // register writes
      if (req.wr) begin
         if (req.addr == wsc_pkg::A_CTRL) begin
            s_d.ext_func = req.wdata[wsc_pkg::F_FUNC +: 8];
            s_d.po_sel = req.wdata[wsc_pkg::F_PO +: 2];
            s_d.show_sel = req.wdata[wsc_pkg::F_SHOW];
            s_d.base = req.wdata[wsc_pkg::F_BASE +: 8];
         end else if (req.addr == wsc_pkg::A_LOAD) begin
            s_d.load_cnt = req.wdata[wsc_pkg::F_LCNT +: 16];
            s_d.first = req.wdata[wsc_pkg::F_FIRST +: 8];
            s_d.last = req.wdata[wsc_pkg::F_LAST +: 8];
         end else if (req.addr == wsc_pkg::A_NEXT) begin
            s_d.nxt_weld = req.wdata[wsc_pkg::F_NWELD +: 8];
            s_d.nxt_off = req.wdata[wsc_pkg::F_NOFF +: 8];
            s_d.nxt_empty = req.wdata[wsc_pkg::F_NEMPTY];
         end else if (req.addr == wsc_pkg::A_STAT) begin
            clr = req.wdata[wsc_pkg::NIRQ-1:0];
         end else if (req.addr == wsc_pkg::A_MASK) begin
            s_d.mask = req.wdata[wsc_pkg::NIRQ-1:0];
         end else if (req.addr == wsc_pkg::A_COUNT) begin
            s_d.count = req.wdata[wsc_pkg::F_CNT +: 16];
            s_d.step = req.wdata[wsc_pkg::F_STEP +: 8];
         end
      end

      // stepper
      if (man_rst || ext_rst) begin
         s_d.count = s_q.load_cnt;
         s_d.step = s_q.first;
         s_d.st = wsc_pkg::ST_RUN;
         ev[wsc_pkg::IRQ_MAN] = man_rst;
         ev[wsc_pkg::IRQ_EXT] = ext_rst;
      end else if (weld_done && count_ok && s_q.st == wsc_pkg::ST_RUN
                   && s_q.count != 16'h0000) begin
         s_d.count = nxt_cnt;
         if (nxt_cnt == 16'h0000) begin
            if (s_q.step != s_q.last) begin
               s_d.step = bcd_inc(s_q.step);
               s_d.count = s_q.load_cnt;
            end else if (s_q.nxt_empty
                         && s_q.nxt_off == wsc_pkg::NEXT_OFF_RST) begin
               s_d.count = s_q.load_cnt;
               s_d.step = s_q.first;
               ev[wsc_pkg::IRQ_AUTO] = 1'b1;
            end else if (s_q.nxt_empty
                         && s_q.nxt_weld == wsc_pkg::NEXT_WELD_END) begin
               s_d.st = wsc_pkg::ST_END;
               ev[wsc_pkg::IRQ_END] = 1'b1;
            end
         end
      end else if (s_q.st == wsc_pkg::ST_END && stop_evt) begin
         s_d.st = wsc_pkg::ST_RUN;
      end

      // blink divider, runs only while the message shows
      if (s_d.st == wsc_pkg::ST_END) begin
         if (s_q.flash_cnt >= FLASH_LAST) begin
            s_d.flash_cnt = '0;
            s_d.flash_on = !s_q.flash_on;
         end else begin
            s_d.flash_cnt = s_q.flash_cnt + FW'(1);
         end
      end else begin
         s_d.flash_cnt = '0;
         s_d.flash_on = 1'b0;
      end
      s_d.valve_io = (s_d.st == wsc_pkg::ST_END)
                     && (s_q.po_sel == wsc_pkg::PO_IO);
      s_d.valve_it = (s_d.st == wsc_pkg::ST_END)
                     && (s_q.po_sel == wsc_pkg::PO_IT);
      s_d.end_msg = (s_d.st == wsc_pkg::ST_END);

      if (seq_end && s_q.show_sel) begin
         s_d.show_cnt = 1'b1;
      end else if (seq_start || !s_q.show_sel) begin
         s_d.show_cnt = 1'b0;
      end

      // set wins over a same-cycle clear
      s_d.stat = (s_q.stat & ~clr) | ev;
      s_d.irq = |(s_d.stat & s_d.mask);

      // read data stands one cycle only
      s_d.rdata = '0;
      if (req.rd) begin
         if (req.addr == wsc_pkg::A_CTRL) begin
            s_d.rdata[wsc_pkg::F_FUNC +: 8] = s_q.ext_func;
            s_d.rdata[wsc_pkg::F_PO +: 2] = s_q.po_sel;
            s_d.rdata[wsc_pkg::F_SHOW] = s_q.show_sel;
            s_d.rdata[wsc_pkg::F_BASE +: 8] = s_q.base;
         end else if (req.addr == wsc_pkg::A_LOAD) begin
            s_d.rdata[wsc_pkg::F_LCNT +: 16] = s_q.load_cnt;
            s_d.rdata[wsc_pkg::F_FIRST +: 8] = s_q.first;
            s_d.rdata[wsc_pkg::F_LAST +: 8] = s_q.last;
         end else if (req.addr == wsc_pkg::A_NEXT) begin
            s_d.rdata[wsc_pkg::F_NWELD +: 8] = s_q.nxt_weld;
            s_d.rdata[wsc_pkg::F_NOFF +: 8] = s_q.nxt_off;
            s_d.rdata[wsc_pkg::F_NEMPTY] = s_q.nxt_empty;
         end else if (req.addr == wsc_pkg::A_STAT) begin
            s_d.rdata[wsc_pkg::NIRQ-1:0] = s_q.stat;
         end else if (req.addr == wsc_pkg::A_MASK) begin
            s_d.rdata[wsc_pkg::NIRQ-1:0] = s_q.mask;
         end else if (req.addr == wsc_pkg::A_COUNT) begin
            s_d.rdata[wsc_pkg::F_CNT +: 16] = s_q.count;
            s_d.rdata[wsc_pkg::F_STEP +: 8] = s_q.step;
            s_d.rdata[wsc_pkg::F_ENDRO] = s_q.end_msg;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_q <= '0;
         s_q.st <= wsc_pkg::ST_RUN;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdata = s_q.rdata;
   assign irq = s_q.irq;
   assign end_msg = s_q.end_msg;
   assign disp_flash = s_q.flash_on;
   assign valve_io = s_q.valve_io;
   assign valve_it = s_q.valve_it;
   assign show_count = s_q.show_cnt;
   assign disp_count = s_q.count;
   assign disp_step = s_q.step;
endmodule

/* File: test/wsc_chk.sv */
`timescale 1ns/1ps
module wsc_chk (
   input wire logic               clk,        // clock
   input wire logic               reset,      // sync reset
   input wire wsc_pkg::wsc_req_t  req,        // register request
   input wire logic [31:0]        rdata,      // read data
   input wire wsc_pkg::wsc_keys_t keys,       // panel keys
   input wire logic               estop,      // emergency stop
   input wire logic               weld_done,  // weld completed
   input wire logic               seq_start,  // sequence begins
   input wire logic               seq_end,    // sequence finished
   input wire logic               end_msg,    // end message
   input wire logic               valve_io,   // process valve
   input wire logic               valve_it,   // third valve
   input wire logic               show_count, // show remaining
   input wire logic [15:0]        disp_count  // bcd count
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_valve_io_end: assert property (valve_io |-> end_msg)
      else $error("valve_io without end message");
   a_valve_it_end: assert property (valve_it |-> end_msg && !valve_io)
      else $error("valve_it without end message");
   a_end_by_weld: assert property ($rose(end_msg) |-> $past(weld_done))
      else $error("end message without weld");
   a_estop_clear: assert property (
      $rose(estop) && end_msg |-> ##[1:6] !end_msg)
      else $error("estop did not clear end message");
   a_key_clear: assert property (
      $rose(keys.other) && end_msg |-> ##[1:6] !end_msg)
      else $error("key did not clear end message");
   a_show_clear: assert property (seq_start && !seq_end |=> !show_count)
      else $error("show_count kept over start");
   a_rdata_idle: assert property (!req.rd |=> rdata == 32'h0)
      else $error("rdata not zero");
   a_count_bcd: assert property (
      disp_count[3:0] <= 4'h9 && disp_count[7:4] <= 4'h9)
      else $error("count digit not decimal");
endmodule
bind wsc_top wsc_chk wsc_chk_i (.*);

/* File: test/wsc_panel.sv */
`timescale 1ns/1ps
module wsc_panel (
   input  wire logic          clk,     // clock
   output wsc_pkg::wsc_keys_t keys,    // panel keys
   output logic               estop,   // emergency stop
   output logic               ext_open // switch line, high = open
);
   initial begin
      keys = '0;
      estop = 1'b0;
      ext_open = 1'b0; // closed to ground when idle
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic combo(); // enter held, then both data keys
      keys.enter <= 1'b1;
      hold(3);
      keys.data1 <= 1'b1;
      keys.data10 <= 1'b1;
      hold(6);
      keys <= '0;
      hold(8);
   endtask
   task automatic other_key();
      keys.other <= 1'b1;
      hold(6);
      keys.other <= 1'b0;
      hold(8);
   endtask
   task automatic stop();
      estop <= 1'b1;
      hold(6);
      estop <= 1'b0;
      hold(8);
   endtask
   task automatic open_sw(); // momentary open
      ext_open <= 1'b1;
      hold(10);
      ext_open <= 1'b0;
      hold(12);
   endtask
endmodule

/* File: test/weld_stepper_counter_tb.sv */
`timescale 1ns/1ps
module weld_stepper_counter_tb;
   logic               clk, reset, weld_done, seq_start, seq_end;
   logic               estop, ext_open, irq, end_msg, disp_flash;
   logic               valve_io, valve_it, show_count;
   wsc_pkg::wsc_req_t  req;
   wsc_pkg::wsc_keys_t keys;
   logic [31:0]        rdata;
   logic [15:0]        disp_count;
   logic [7:0]         disp_step;
   int                 fail_count, compares, cyc;
   wsc_top #(.DEB_CYC(4), .FLASH_CYC(8)) wsc_top_i (.clk(clk),
      .reset(reset), .req(req), .rdata(rdata), .irq(irq), .keys(keys),
      .estop(estop), .external_reset_input(ext_open), .weld_done(weld_done),
      .seq_start(seq_start), .seq_end(seq_end), .end_msg(end_msg),
      .disp_flash(disp_flash), .valve_io(valve_io), .valve_it(valve_it),
      .show_count(show_count), .disp_count(disp_count),
      .disp_step(disp_step));
   wsc_panel wsc_panel_i (.clk(clk), .keys(keys), .estop(estop),
      .ext_open(ext_open));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %0t got %h expected %h", $time, s, e);
      end
   endtask
   task automatic cnt(input logic [15:0] c, input logic [7:0] s);
      chk({16'h0, disp_step, disp_count[7:0]}, {16'h0, s, c[7:0]});
      chk({16'h0, disp_count}, {16'h0, c});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk) req <= '{1'b1, 1'b0, a, v};
      @(posedge clk) req <= '0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk) req <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge clk) req <= '0;
      #1 chk(rdata, e);
   endtask
   task automatic weld(input int n);
      repeat (n) begin
         @(posedge clk) weld_done <= 1'b1;
         @(posedge clk) weld_done <= 1'b0;
      end
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic t_count();
      wr(wsc_pkg::A_CTRL, 32'h0010_0505);
      wr(wsc_pkg::A_LOAD, 32'h0100_0002);
      wr(wsc_pkg::A_NEXT, 32'h0001_0001);
      wr(wsc_pkg::A_MASK, 32'h0000_0001);
      wsc_panel_i.combo();
      cnt(16'h0002, 8'h00);
      rd(wsc_pkg::A_STAT, 32'h0000_0008);
      wr(wsc_pkg::A_STAT, 32'h0000_000f);
      weld(1);
      cnt(16'h0001, 8'h00);
      weld(1);
      cnt(16'h0002, 8'h01);
      weld(2);
      chk({end_msg, valve_io, valve_it, irq}, 4'b1101);
      weld(1);
      cnt(16'h0000, 8'h01);
      wsc_panel_i.other_key();
      chk({end_msg, valve_io, disp_flash}, 3'b000);
      wr(wsc_pkg::A_STAT, 32'h0000_000f);
      chk(irq, 1'b0);
      $display("count test ended");
   endtask
   task automatic t_estop();
      wsc_panel_i.combo();
      wr(wsc_pkg::A_CTRL, 32'h0010_0605);
      weld(4);
      chk({end_msg, valve_io, valve_it}, 3'b101);
      chk(disp_flash, 1'b0);
      // blink phase flips after 7 and again after 15 cycles
      repeat (5) @(posedge clk);
      #1 chk(disp_flash, 1'b1);
      repeat (8) @(posedge clk);
      #1 chk(disp_flash, 1'b0);
      wsc_panel_i.stop();
      chk({end_msg, valve_it}, 2'b00);
      $display("estop test ended");
   endtask
   task automatic t_ext();
      wr(wsc_pkg::A_CTRL, 32'h0010_0400);
      wr(wsc_pkg::A_COUNT, 32'h0001_0005);
      wr(wsc_pkg::A_STAT, 32'h0000_000f);
      wsc_panel_i.open_sw();
      cnt(16'h0005, 8'h01);
      wr(wsc_pkg::A_CTRL, 32'h0010_0405);
      wsc_panel_i.open_sw();
      cnt(16'h0002, 8'h00);
      rd(wsc_pkg::A_STAT, 32'h0000_0002);
      $display("external test ended");
   endtask
   task automatic t_auto();
      wr(wsc_pkg::A_NEXT, 32'h0001_9900);
      wr(wsc_pkg::A_STAT, 32'h0000_000f);
      weld(4);
      cnt(16'h0002, 8'h00);
      rd(wsc_pkg::A_STAT, 32'h0000_0004);
      wr(wsc_pkg::A_CTRL, 32'h0015_0400);
      weld(1);
      cnt(16'h0002, 8'h00);
      rd(8'h20, 32'h0);
      $display("auto test ended");
   endtask
   task automatic t_show();
      @(posedge clk) seq_end <= 1'b1;
      @(posedge clk) seq_end <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(show_count, 1'b1);
      @(posedge clk) seq_start <= 1'b1;
      @(posedge clk) seq_start <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk(show_count, 1'b0);
      $display("show test ended");
   endtask
   task automatic t_reset();
      @(posedge clk) reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      #1 chk({disp_count, disp_step, end_msg, show_count, irq}, 32'h0);
      rd(wsc_pkg::A_COUNT, 32'h0);
      rd(wsc_pkg::A_STAT, 32'h0);
      $display("reset test ended");
   endtask
   initial begin
      reset = 1'b1;
      req = '0;
      weld_done = 1'b0;
      seq_start = 1'b0;
      seq_end = 1'b0;
      fail_count = 0;
      compares = 0;
      cyc = 0;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      t_count();
      t_estop();
      t_ext();
      t_show();
      t_auto();
      t_reset();
      conclude();
   end
endmodule
